// ===== verilog/sar_adc_pkg.sv
// Package with constants and carrier types for the converter host port.
`default_nettype none
package sar_adc_pkg;
    localparam int RES_BITS = 12;
    localparam int BUS_BITS = 8;
    // Register indices (word addresses on the Wishbone slave).
    localparam logic [3:0] IDX_CTRL = 4'h0;
    localparam logic [3:0] IDX_RES_LO = 4'h1;
    localparam logic [3:0] IDX_RES_HI = 4'h2;
    localparam logic [3:0] IDX_CFG = 4'h3;
    // Control byte layout: channel[2:0], gain[4:3], start[7].
    localparam int CTRL_CH_LSB = 0;
    localparam int CTRL_GAIN_LSB = 3;
    localparam int CTRL_START_BIT = 7;
    // Config byte layout: resolution[3:0], clock divide[6:4], twos[7].
    localparam int CFG_DIV_LSB = 4;
    localparam int CFG_TWOS_BIT = 7;
    localparam logic [3:0] CFG_RES_RESET = 4'hc;
    localparam logic [3:0] RES_MIN = 4'h1;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] STATUS_BUSY_MASK = 8'h80;
    // Settling delay and start pulse width.
    localparam int CLK_MHZ = 100;
    localparam int SETTLE_NS = 2000;
    localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int START_NS = 50;
    localparam int START_CYC = (START_NS * CLK_MHZ + 999) / 1000;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETTLE = 3'b001,
        ST_START = 3'b010,
        ST_CONVERT = 3'b011,
        ST_DONE = 3'b100
    } conv_state_t;

    typedef struct packed {
        logic [2:0] channel;
        logic [1:0] gain;
    } front_end_t;

    typedef struct packed {
        logic [3:0] res_bits;
        logic [2:0] clk_div;
        logic twos;
    } conv_cfg_t;
endpackage : sar_adc_pkg
`default_nettype wire

// ===== verilog/sar_register.sv
// Successive-approximation register that resolves one bit per approximation clock.
`default_nettype none
module sar_register #(
    parameter int WIDTH = 12
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic start_i,
    input wire logic step_i,
    input wire logic [3:0] res_bits_i,
    input wire logic comp_i,
    // State
    output logic [WIDTH-1:0] bits_o,
    output logic conversion_done_flag_o
);
    logic [WIDTH-1:0] mask;
    logic [WIDTH-1:0] res_lsb;

    // One-hot marker of the last bit that the short-cycled conversion decides.
    assign res_lsb = {{(WIDTH-1){1'b0}}, 1'b1} << (WIDTH[3:0] - res_bits_i);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bits_o <= '0;
            mask <= '0;
            conversion_done_flag_o <= 1'b0;
        end else if (start_i) begin
            bits_o <= {1'b0, {(WIDTH-1){1'b1}}};
            mask <= {1'b1, {(WIDTH-1){1'b0}}};
            conversion_done_flag_o <= 1'b1;
        end else if (step_i && conversion_done_flag_o) begin
            // The decided bit takes the comparator, the next bit becomes the trial and the rest below clear.
            bits_o <= (bits_o & ~(mask | (mask - {{(WIDTH-1){1'b0}}, 1'b1}))) | ({WIDTH{comp_i}} & mask) |
                      (mask >> 1);
            mask <= mask >> 1;
            if (mask == res_lsb) begin
                conversion_done_flag_o <= 1'b0;
            end
        end
    end
endmodule : sar_register
`default_nettype wire

// ===== verilog/sar_adc_host_port.sv
// Host port, start sequencing and readout for the 12-bit successive-approximation converter.
//
// Chosen here: the register offsets and register access over Wishbone.
`default_nettype none
// Overview of operation
// - Two's-complement readout inverts the approximation top bit for the host.
// - The DAC always gets the non-inverted approximation register bits.
// - Short cycling ends conversion once the chosen new least significant bit is decided.
// - Software selects resolution and approximation clock rate.
// - One control write sets channel, gain and starts the sequence.
// - A settling delay separates front-end setup from the converter start.
// - Busy holds the sample-and-hold for the whole approximation.
// - End of conversion can raise a host interrupt request.
// - Result reaches the host bus only on a read, after conversion.
// - Writes land in a clocked latch, reads through enabled buffers, only on strobes.
// - Two 8-bit result read groups and two 8-bit write registers (control, config) exist.
// - All four word address lines are decoded; the byte address lines are not.
// - Read and write act only while the address decode is active.
// - The port select bit chooses the upper result group when high.
// - Same strobe gating serves I/O-mapped and memory-mapped use.
// - Start sets done high, top bit zero and the rest ones.
// - Approximation begins only after the start pulse returns low.
// - The last approximation clock decides the final bit and drops done.
module sar_adc_host_port #(
    parameter int RES_BITS = sar_adc_pkg::RES_BITS,
    parameter int SETTLE_CYC = sar_adc_pkg::SETTLE_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [5:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Analog front end
    input wire logic comp_i,
    output sar_adc_pkg::front_end_t front_end_o,
    output logic [RES_BITS-1:0] dac_code_o,
    output logic hold_o,
    // Host status
    output logic conversion_done_flag_o,
    output logic irq_o
);
    sar_adc_pkg::conv_state_t state;
    sar_adc_pkg::conv_state_t next_state;
    sar_adc_pkg::conv_cfg_t cfg;
    logic [7:0] ctrl_latch;
    logic [15:0] count;
    logic [2:0] div_count;
    logic approx_clock_input;
    logic sar_start;
    logic busy;
    logic busy_q;
    logic [RES_BITS-1:0] sar_bits;
    logic [RES_BITS-1:0] result;
    logic acc;
    logic wr_strobe;
    logic rd_strobe;
    logic [3:0] reg_idx;
    logic addr_hit;

    // Word index; all four word address lines are decoded, not only those the map needs.
    assign reg_idx = adr_i[5:2];
    // Address decode, active only for mapped registers; strobes come from the bus alone.
    assign addr_hit = (reg_idx <= sar_adc_pkg::IDX_CFG);
    assign acc = cyc_i && stb_i && !ack_o;
    assign wr_strobe = acc && we_i && addr_hit && sel_i[0];
    assign rd_strobe = acc && !we_i && addr_hit;

    // Control latch: channel, gain and start bit in one write.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_latch <= sar_adc_pkg::CTRL_RESET;
        end else if (wr_strobe && reg_idx == sar_adc_pkg::IDX_CTRL) begin
            ctrl_latch <= dat_i[7:0];
        end
    end

    assign front_end_o.channel = ctrl_latch[sar_adc_pkg::CTRL_CH_LSB +: 3];
    assign front_end_o.gain = ctrl_latch[sar_adc_pkg::CTRL_GAIN_LSB +: 2];

    // Resolution and clock divide set by software; resolution is clamped to a legal range.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg <= '{res_bits: sar_adc_pkg::CFG_RES_RESET, clk_div: 3'h0, twos: 1'b0};
        end else if (wr_strobe && reg_idx == sar_adc_pkg::IDX_CFG) begin
            cfg.res_bits <= (dat_i[3:0] < sar_adc_pkg::RES_MIN) ? sar_adc_pkg::RES_MIN :
                            (dat_i[3:0] > sar_adc_pkg::CFG_RES_RESET) ? sar_adc_pkg::CFG_RES_RESET :
                            dat_i[3:0];
            cfg.clk_div <= dat_i[sar_adc_pkg::CFG_DIV_LSB +: 3];
            cfg.twos <= dat_i[sar_adc_pkg::CFG_TWOS_BIT];
        end
    end

    // Sequencer: settle, start pulse, approximation, done.
    always_comb begin
        next_state = state;
        unique case (state)
            sar_adc_pkg::ST_IDLE: begin
                if (wr_strobe && reg_idx == sar_adc_pkg::IDX_CTRL && dat_i[sar_adc_pkg::CTRL_START_BIT]) begin
                    next_state = sar_adc_pkg::ST_SETTLE;
                end
            end
            sar_adc_pkg::ST_SETTLE: begin
                if (count == 16'(SETTLE_CYC - 1)) begin
                    next_state = sar_adc_pkg::ST_START;
                end
            end
            sar_adc_pkg::ST_START: begin
                if (count == 16'(sar_adc_pkg::START_CYC - 1)) begin
                    next_state = sar_adc_pkg::ST_CONVERT;
                end
            end
            sar_adc_pkg::ST_CONVERT: begin
                if (busy_q && !busy) begin
                    next_state = sar_adc_pkg::ST_DONE;
                end
            end
            sar_adc_pkg::ST_DONE: begin
                if (wr_strobe && reg_idx == sar_adc_pkg::IDX_CTRL && dat_i[sar_adc_pkg::CTRL_START_BIT]) begin
                    next_state = sar_adc_pkg::ST_SETTLE;
                end
            end
            default: next_state = sar_adc_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= sar_adc_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || next_state != state) begin
            count <= 16'h0000;
        end else begin
            count <= count + 16'h0001;
        end
    end

    // Approximation clock divider, running only after the start pulse has ended.
    always_ff @(posedge clk_i) begin
        if (rst_i || state != sar_adc_pkg::ST_CONVERT) begin
            div_count <= 3'h0;
        end else if (div_count == cfg.clk_div) begin
            div_count <= 3'h0;
        end else begin
            div_count <= div_count + 3'h1;
        end
    end

    assign approx_clock_input = (state == sar_adc_pkg::ST_CONVERT) && (div_count == cfg.clk_div);
    assign sar_start = (state == sar_adc_pkg::ST_START) && (count == 16'h0000);

    sar_register #(
        .WIDTH(RES_BITS)
    ) u_sar (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(sar_start),
        .step_i(approx_clock_input),
        .res_bits_i(cfg.res_bits),
        .comp_i(comp_i),
        .bits_o(sar_bits),
        .conversion_done_flag_o(busy)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= busy;
        end
    end

    assign dac_code_o = sar_bits;
    assign hold_o = busy;
    assign conversion_done_flag_o = busy;

    // Host copy of the result, top bit inverted for two's-complement coding.
    assign result = {sar_bits[RES_BITS-1] ^ cfg.twos, sar_bits[RES_BITS-2:0]};

    // End-of-conversion request, cleared by reading the upper result group; a new end wins.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else if (busy_q && !busy) begin
            irq_o <= 1'b1;
        end else if (rd_strobe && reg_idx == sar_adc_pkg::IDX_RES_HI) begin
            irq_o <= 1'b0;
        end
    end

    // Read groups: low byte, and upper bits with status; result only while not busy.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= sar_adc_pkg::DATA_ZERO;
        end else if (rd_strobe) begin
            unique case (reg_idx)
                sar_adc_pkg::IDX_CTRL: dat_o <= {24'h00_0000, ctrl_latch};
                sar_adc_pkg::IDX_RES_LO: dat_o <= busy ? sar_adc_pkg::DATA_ZERO :
                                                  {24'h00_0000, result[7:0]};
                sar_adc_pkg::IDX_RES_HI: dat_o <= {24'h00_0000, (busy ? sar_adc_pkg::STATUS_BUSY_MASK : 8'h00) |
                                                  (busy ? 8'h00 : {4'h0, result[RES_BITS-1:8]})};
                sar_adc_pkg::IDX_CFG: dat_o <= {24'h00_0000, cfg.twos, cfg.clk_div, cfg.res_bits};
                default: dat_o <= sar_adc_pkg::DATA_ZERO;
            endcase
        end else begin
            dat_o <= sar_adc_pkg::DATA_ZERO;
        end
    end

    // Single-cycle acknowledge for every access, mapped or not; unmapped reads return zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= acc;
        end
    end
endmodule : sar_adc_host_port
`default_nettype wire

// ===== tb/sar_adc_host_port_properties.sv
// Concurrent checks on the converter host port.
`default_nettype none
module sar_adc_host_port_properties (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [5:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // Converter side
    input wire sar_adc_pkg::front_end_t front_end_o,
    input wire logic hold_o,
    input wire logic conversion_done_flag_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic req;
    logic hi_rd;
    logic go;
    assign req = cyc_i && stb_i && !ack_o;
    assign hi_rd = cyc_i && stb_i && !we_i && adr_i[5:2] == 4'h2;
    assign go = req && we_i && adr_i[5:2] == 4'h0 && sel_i[0] && dat_i[7] && !conversion_done_flag_o;
    a_ack_next: assert property (req |=> ack_o) else $error("ack missing");
    a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack too long");
    a_dat_quiet: assert property (!ack_o |-> dat_o == 32'h0000_0000) else $error("data driven idle");
    a_hold_busy: assert property (hold_o == conversion_done_flag_o) else $error("hold differs from busy");
    a_settle_gap: assert property (go |=> !conversion_done_flag_o [*3] ##[1:20] conversion_done_flag_o)
        else $error("start not delayed");
    a_start_width: assert property ($rose(conversion_done_flag_o) |-> conversion_done_flag_o [*5])
        else $error("busy too short");
    a_end_bound: assert property ($rose(conversion_done_flag_o) |-> ##[5:200] !conversion_done_flag_o)
        else $error("conversion never ends");
    a_irq_set: assert property ($fell(conversion_done_flag_o) |=> irq_o) else $error("irq not raised");
    a_irq_clear: assert property ($fell(irq_o) |-> $past(hi_rd)) else $error("irq cleared early");
    a_fe_latch: assert property ($changed(front_end_o) |-> $past(req && we_i && adr_i[5:2] == 4'h0 && sel_i[0]))
        else $error("front end changed without write");
    c_conv: cover property ($fell(conversion_done_flag_o));
    c_irq: cover property ($fell(irq_o));
    c_fe: cover property ($changed(front_end_o));
endmodule : sar_adc_host_port_properties
bind sar_adc_host_port sar_adc_host_port_properties i_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .front_end_o(front_end_o), .hold_o(hold_o), .conversion_done_flag_o(conversion_done_flag_o), .irq_o(irq_o));
`default_nettype wire

// ===== tb/analog_model.sv
// Comparator and signal source standing in for the analog front end.
`default_nettype none
module analog_model (
    // Trial code and input level
    input wire logic [11:0] dac_code_i,
    input wire logic [11:0] level_i,
    // Comparator decision
    output logic comp_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Keeps the trial bit while the input is at or above the trial code.
    assign comp_o = level_i >= dac_code_i;
endmodule : analog_model
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the converter host port.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [5:0] adr_i = 6'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000;
    logic [31:0] dat_o;
    logic ack_o;
    logic comp_i;
    sar_adc_pkg::front_end_t front_end_o;
    logic [11:0] dac_code_o;
    logic hold_o;
    logic conversion_done_flag_o;
    logic irq_o;
    logic [11:0] level = 12'h000;
    logic [15:0] lfsr = 16'h002d;
    logic [31:0] q;
    int miscompares = 0;
    int comparisons = 0;
    sar_adc_host_port #(.SETTLE_CYC(4)) i_sar_adc_host_port (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .comp_i(comp_i), .front_end_o(front_end_o), .dac_code_o(dac_code_o), .hold_o(hold_o),
        .conversion_done_flag_o(conversion_done_flag_o), .irq_o(irq_o));
    analog_model i_analog_model (.dac_code_i(dac_code_o), .level_i(level), .comp_o(comp_i));
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    // Reference approximation: start from top bit zero and the rest ones, then one bit per step.
    function automatic logic [11:0] sar_expect(input logic [11:0] lv, input int r);
        logic [11:0] code;
        logic [11:0] bit_k;
        code = 12'h7ff;
        for (int k = 11; k >= 12 - r; k--) begin
            bit_k = 12'h001 << k;
            code = (code & ~(bit_k | (bit_k - 12'h001))) | ((lv >= code) ? bit_k : 12'h000) | (bit_k >> 1);
        end
        return code;
    endfunction : sar_expect
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out
    // One classic Wishbone cycle; waits for the acknowledge, checks it and captures the read data.
    task automatic wb(input logic w, input logic [3:0] idx, input logic [7:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {idx, 2'b00};
        sel_i <= s;
        dat_i <= {24'h00_0000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        chk({31'h0, ack_o}, 32'h0000_0001);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask : wb
    task automatic wait_flag(input logic v);
        int n;
        n = 0;
        while (conversion_done_flag_o !== v && n < 400) begin
            @(posedge clk_i);
            n++;
        end
        chk({31'h0, conversion_done_flag_o}, {31'h0, v});
    endtask : wait_flag
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        #900_000;
        miscompares++;
        close_out();
    end
    initial begin
        logic [7:0] cfg;
        logic [7:0] ctl;
        logic [11:0] m;
        logic [11:0] e;
        logic [3:0] tab [5];
        int r;
        tab = '{4'hc, 4'h8, 4'h1, 4'h0, 4'hf};
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 4'h3, 8'h00, 4'h1);
        chk(q, 32'h0000_000c);
        wb(1'b1, 4'h9, 8'hff, 4'h1);
        wb(1'b0, 4'h9, 8'h00, 4'h1);
        chk(q, 32'h0000_0000);
        wb(1'b1, 4'h0, 8'h9d, 4'h0);
        repeat (30) @(posedge clk_i);
        chk({26'h0, front_end_o, conversion_done_flag_o}, 32'h0000_0000);
        for (int i = 0; i < 10; i++) begin
            lfsr = lfsr_next(lfsr);
            cfg = {lfsr[7:4], (i < 5) ? tab[i] : lfsr[3:0]};
            r = (cfg[3:0] == 4'h0) ? 1 : (cfg[3:0] > 4'hc) ? 12 : int'(cfg[3:0]);
            m = 12'hfff << (12 - r);
            level <= lfsr[15:4];
            wb(1'b1, 4'h3, cfg, 4'h1);
            ctl = {1'b1, lfsr[9:3]};
            wb(1'b1, 4'h0, ctl, 4'h1);
            chk({27'h0, front_end_o}, {27'h0, ctl[2:0], ctl[4:3]});
            e = (sar_expect(lfsr[15:4], r) & m) ^ {cfg[7], 11'h000};
            wait_flag(1'b1);
            wb(1'b0, 4'h2, 8'h00, 4'h1);
            chk(q, 32'h0000_0080);
            wait_flag(1'b0);
            repeat (2) @(posedge clk_i);
            chk({31'h0, irq_o}, 32'h0000_0001);
            wb(1'b0, 4'h1, 8'h00, 4'h1);
            chk({23'h00_0000, q[7:0] & m[7:0], irq_o}, {23'h00_0000, e[7:0], 1'b1});
            wb(1'b0, 4'h2, 8'h00, 4'h1);
            chk({28'h000_0000, q[3:0] & m[11:8]}, {28'h000_0000, e[11:8]});
            repeat (2) @(posedge clk_i);
            chk({31'h0, irq_o}, 32'h0000_0000);
        end
        close_out();
    end
endmodule : tb
`default_nettype wire
